// ===== hw/position_status.sv
// position_status: positioning completed / near flags and force-control speed limit, with an
// AXI4-Lite register file and a masked level interrupt.
// assumes all inputs are synchronous to mclk and refreshed once per control cycle.
//
// Function
// - completed flag when |reference minus travelled| is below completed width, default 7.
// - timing selector 1 also needs filtered position reference zero; applied at restart.
// - timing selector 2 also needs raw position reference input zero; 0 is width only.
// - near flag while position error is below near width, default 2^30, immediate.
// - each flag reaches its output terminal only when its allocation bit is set.
// - speed-limit flag while speed has reached the active limit, low when none applied.
// - speed limiting is applied during force control only; speed_limit_value is driven in every mode, only the flag needs force.
// - mode selector picks internal limit or external commanded limit; applied at restart.
// - ceiling selector clamps limit by max motor speed or overspeed speed; at restart.
// - internal limit any 16-bit value, default 10000, clamped by the chosen ceiling.
`timescale 1ns/1ps
`default_nettype none

module position_status (
	input  wire logic                             mclk,
	input  wire logic                             nrst,
	input  wire position_status_pkg::axi_req_t    axi_req,
	output var  position_status_pkg::axi_rsp_t    axi_rsp,
	input  wire logic signed [31:0]               reference_count,
	input  wire logic signed [31:0]               travelled_distance,
	input  wire logic signed [31:0]               filtered_reference,
	input  wire logic signed [31:0]               reference_input,
	input  wire logic signed [15:0]               motor_speed,
	input  wire logic [15:0]                      external_speed_limit_value,
	output logic                                  positioning_completed_flag,
	output logic                                  positioning_near_flag,
	output logic                                  speed_limit_active_flag,
	output logic [15:0]                           speed_limit_value,
	output logic                                  irq
);
	import position_status_pkg::*;

	state_t      s;
	state_t      n;
	logic [32:0] err;
	logic [32:0] abs_err;
	logic [15:0] abs_speed;
	logic [15:0] lim_src;
	logic [15:0] ceiling;
	logic [15:0] lim_new;
	logic        ref_quiet;
	logic        comp_raw;
	logic        near_raw;
	logic        vlt_raw;
	logic        wr_go;
	logic        restart_wr;

	// byte-lane merge for a partial AXI write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// position error, wide enough that the subtraction and its magnitude never wrap
	assign err       = {reference_count[31], reference_count} -
		{travelled_distance[31], travelled_distance};
	assign abs_err   = err[32] ? 33'(~err + 33'h1) : err;
	assign abs_speed = motor_speed[15] ? 16'(~motor_speed + 16'h1) : motor_speed;

	// completed qualifier chosen by the active timing selector
	always_comb begin
		case (s.timing_act)
			TIMING_FILTERED: ref_quiet = (filtered_reference == 32'h0);
			TIMING_INPUT:    ref_quiet = (reference_input == 32'h0);
			default:         ref_quiet = 1'b1;
		endcase
	end

	// raw flag conditions, evaluated afresh each cycle
	assign comp_raw = s.ctrl[CTRL_POS_BIT] && (abs_err < {2'h0, s.comp_width}) && ref_quiet;
	assign near_raw = s.ctrl[CTRL_POS_BIT] && (abs_err < {2'h0, s.near_width});
	assign vlt_raw  = s.ctrl[CTRL_FORCE_BIT] && (abs_speed >= s.limit);

	// limit source and ceiling; an oversized setting falls back to the ceiling
	assign lim_src = s.mode_act ? external_speed_limit_value : s.int_limit;
	assign ceiling = s.ceil_act ? s.overspeed : s.max_speed;
	assign lim_new = (lim_src < ceiling) ? lim_src : ceiling;

	assign wr_go      = s.aw_have && s.w_have && !s.rsp.bvalid;
	assign restart_wr = wr_go && (s.aw_addr == CTRL_OFS) && s.w_strb[1] &&
		s.w_data[CTRL_RESTART_BIT];

	// next state: bus slave, register file, flags and interrupt
	always_comb begin
		logic [31:0] wv;
		logic [2:0]  ev;
		n  = s;
		wv = 32'h0;
		ev = 3'h0;
		// write address and data are taken independently, in either order
		if (axi_req.awvalid && s.rsp.awready) begin
			n.aw_have = 1'b1;
			n.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s.rsp.wready) begin
			n.w_have = 1'b1;
			n.w_data = axi_req.wdata;
			n.w_strb = axi_req.wstrb;
		end
		if (s.rsp.bvalid && axi_req.bready) begin
			n.rsp.bvalid = 1'b0;
		end
		if (wr_go) begin
			n.aw_have     = 1'b0;
			n.w_have      = 1'b0;
			n.rsp.bvalid  = 1'b1;
			n.rsp.bresp   = RESP_OKAY;
			case ({s.aw_addr[7:2], 2'h0})
				CTRL_OFS: begin
					wv     = merge({25'h0, s.ctrl}, s.w_data, s.w_strb);
					n.ctrl = wv[6:0];
				end
				SELECT_OFS: begin
					wv            = merge({23'h0, s.ceil_pend, 3'h0, s.mode_pend, 2'h0,
						s.timing_pend}, s.w_data, s.w_strb);
					n.timing_pend = wv[SEL_TIMING_LSB +: 2];
					n.mode_pend   = wv[SEL_MODE_BIT];
					n.ceil_pend   = wv[SEL_CEIL_BIT];
				end
				COMP_WIDTH_OFS: begin
					wv           = merge({1'b0, s.comp_width}, s.w_data, s.w_strb);
					n.comp_width = wv[30:0];
				end
				NEAR_WIDTH_OFS: begin
					wv           = merge({1'b0, s.near_width}, s.w_data, s.w_strb);
					n.near_width = wv[30:0];
				end
				INT_LIMIT_OFS: begin
					wv          = merge({16'h0, s.int_limit}, s.w_data, s.w_strb);
					n.int_limit = wv[15:0];
				end
				MAX_SPEED_OFS: begin
					wv          = merge({16'h0, s.max_speed}, s.w_data, s.w_strb);
					n.max_speed = wv[15:0];
				end
				OVERSPEED_OFS: begin
					wv          = merge({16'h0, s.overspeed}, s.w_data, s.w_strb);
					n.overspeed = wv[15:0];
				end
				IRQ_MASK_OFS: begin
					wv         = merge({29'h0, s.irq_mask}, s.w_data, s.w_strb);
					n.irq_mask = wv[2:0];
				end
				IRQ_STAT_OFS: ;
				STATUS_OFS: ;
				LIMIT_OFS: ;
				default: n.rsp.bresp = RESP_SLVERR;
			endcase
		end
		// selectors take effect only on a restart, never mid-motion
		if (restart_wr) begin
			n.timing_act = timing_t'(s.timing_pend);
			n.mode_act   = s.mode_pend;
			n.ceil_act   = s.ceil_pend;
		end
		n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
		n.rsp.wready  = !n.w_have && !n.rsp.bvalid;
		// read channel: one read outstanding, answer one edge after the address
		if (s.rsp.rvalid && axi_req.rready) begin
			n.rsp.rvalid  = 1'b0;
			n.rsp.arready = 1'b1;
		end
		if (axi_req.arvalid && s.rsp.arready) begin
			n.rsp.arready = 1'b0;
			n.rsp.rvalid  = 1'b1;
			n.rsp.rresp   = RESP_OKAY;
			case ({axi_req.araddr[7:2], 2'h0})
				CTRL_OFS:       n.rsp.rdata = {25'h0, s.ctrl};
				SELECT_OFS:     n.rsp.rdata = {23'h0, s.ceil_pend, 3'h0, s.mode_pend, 2'h0,
					s.timing_pend};
				COMP_WIDTH_OFS: n.rsp.rdata = {1'b0, s.comp_width};
				NEAR_WIDTH_OFS: n.rsp.rdata = {1'b0, s.near_width};
				INT_LIMIT_OFS:  n.rsp.rdata = {16'h0, s.int_limit};
				MAX_SPEED_OFS:  n.rsp.rdata = {16'h0, s.max_speed};
				OVERSPEED_OFS:  n.rsp.rdata = {16'h0, s.overspeed};
				STATUS_OFS:     n.rsp.rdata = {19'h0, s.ceil_act, 3'h0, s.mode_act, 2'h0,
					s.timing_act, 1'b0, s.vlt, s.near, s.completed};
				LIMIT_OFS:      n.rsp.rdata = {16'h0, s.limit};
				IRQ_STAT_OFS:   n.rsp.rdata = {29'h0, s.irq_stat};
				IRQ_MASK_OFS:   n.rsp.rdata = {29'h0, s.irq_mask};
				default: begin
					n.rsp.rdata = 32'h0;
					n.rsp.rresp = RESP_SLVERR;
				end
			endcase
		end
		// flags re-evaluated every cycle, gated onto terminals by allocation
		n.limit         = lim_new;
		n.completed     = comp_raw;
		n.near          = near_raw;
		n.vlt           = vlt_raw;
		n.completed_out = comp_raw && s.ctrl[CTRL_ALLOC_C_BIT];
		n.near_out      = near_raw && s.ctrl[CTRL_ALLOC_N_BIT];
		n.vlt_out       = vlt_raw && s.ctrl[CTRL_ALLOC_V_BIT];
		// rising flags are events; a set in the clearing cycle wins
		ev = {vlt_raw && !s.vlt, near_raw && !s.near, comp_raw && !s.completed};
		if (wr_go && ({s.aw_addr[7:2], 2'h0} == IRQ_STAT_OFS)) begin
			n.irq_stat = s.irq_stat & ~(s.w_data[2:0] & {3{s.w_strb[0]}});
		end
		n.irq_stat = n.irq_stat | ev;
		n.irq      = |(n.irq_stat & n.irq_mask);
	end

	// single state register
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s             <= '0;
			s.rsp.awready <= 1'b1;
			s.rsp.wready  <= 1'b1;
			s.rsp.arready <= 1'b1;
			s.timing_act  <= TIMING_ERROR_ONLY;
			s.comp_width  <= COMP_WIDTH_RST;
			s.near_width  <= NEAR_WIDTH_RST;
			s.int_limit   <= INT_LIMIT_RST;
			s.max_speed   <= MAX_SPEED_RST;
			s.overspeed   <= OVERSPEED_RST;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state register
	assign axi_rsp                    = s.rsp;
	assign positioning_completed_flag = s.completed_out;
	assign positioning_near_flag      = s.near_out;
	assign speed_limit_active_flag    = s.vlt_out;
	assign speed_limit_value          = s.limit;
	assign irq                        = s.irq;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence both_taken;
		s.aw_have && s.w_have && !s.rsp.bvalid;
	endsequence

	sequence resp_shown;
		s.rsp.bvalid ##0 !s.aw_have;
	endsequence

	comp_width_a: assert property ((abs_err >= {2'h0, s.comp_width}) |=> !s.completed)
		else $error("completed set with error at or above width");
	comp_filter_a: assert property ((s.timing_act == TIMING_FILTERED &&
		filtered_reference != 32'h0) |=> !s.completed)
		else $error("completed set while filtered reference moving");
	comp_input_a: assert property ((s.timing_act == TIMING_INPUT &&
		reference_input != 32'h0) |=> !s.completed)
		else $error("completed set while reference input moving");
	near_width_a: assert property ((s.ctrl[CTRL_POS_BIT] &&
		abs_err < {2'h0, s.near_width}) |=> s.near)
		else $error("near not set inside near width");
	near_far_a: assert property ((abs_err >= {2'h0, s.near_width})
		|=> !s.near)
		else $error("near set outside near width");
	pos_off_a: assert property (!s.ctrl[CTRL_POS_BIT]
		|=> !s.near && !s.completed)
		else $error("position flag set outside position control");
	// a terminal shows its flag only if the allocation stood when the flag was taken
	alloc_gate_a: assert property (positioning_completed_flag ==
		(s.completed && $past(s.ctrl[CTRL_ALLOC_C_BIT])))
		else $error("completed terminal disagrees with its allocation");
	alloc_near_a: assert property (positioning_near_flag ==
		(s.near && $past(s.ctrl[CTRL_ALLOC_N_BIT])))
		else $error("near terminal disagrees with its allocation");
	alloc_limit_a: assert property (speed_limit_active_flag ==
		(s.vlt && $past(s.ctrl[CTRL_ALLOC_V_BIT])))
		else $error("speed limit terminal disagrees with its allocation");
	vlt_force_a: assert property (!s.ctrl[CTRL_FORCE_BIT] |=> !s.vlt ##1
		!speed_limit_active_flag or s.ctrl[CTRL_FORCE_BIT])
		else $error("speed limit flag outside force control");
	vlt_reach_a: assert property ((s.ctrl[CTRL_FORCE_BIT] && abs_speed >= s.limit) |=> s.vlt)
		else $error("speed limit reached but flag low");
	vlt_idle_a: assert property ((s.ctrl[CTRL_FORCE_BIT] &&
		abs_speed < s.limit) |=> !s.vlt)
		else $error("speed limit flag set below the limit");
	limit_clamp_a: assert property (1'b1 |=> speed_limit_value <= $past(ceiling))
		else $error("speed limit above ceiling");
	limit_source_a: assert property ((!s.mode_act && s.int_limit < ceiling)
		|=> speed_limit_value == $past(s.int_limit))
		else $error("internal limit not applied");
	limit_ext_a: assert property ((s.mode_act &&
		external_speed_limit_value < ceiling) |=> speed_limit_value ==
		$past(external_speed_limit_value))
		else $error("external limit not applied");
	limit_ceil_a: assert property ((lim_src >= ceiling)
		|=> speed_limit_value == $past(ceiling))
		else $error("oversized limit not replaced by ceiling");
	restart_hold_a: assert property (!restart_wr |=> $stable(s.mode_act) &&
		$stable(s.ceil_act) && $stable(s.timing_act))
		else $error("selector changed without restart");
	restart_load_a: assert property (restart_wr |=>
		s.mode_act == $past(s.mode_pend) && s.ceil_act == $past(s.ceil_pend))
		else $error("selector not loaded at restart");
	write_resp_a: assert property (both_taken |=> resp_shown)
		else $error("write response missing");

	sequence read_taken;
		axi_req.arvalid && s.rsp.arready;
	endsequence

	sequence read_shown;
		s.rsp.rvalid ##0 !s.rsp.arready;
	endsequence

	// bus checks: an answer stands until its ready, and a busy write address channel takes nothing
	read_resp_a: assert property (read_taken |=> read_shown)
		else $error("read answer missing");
	write_hold_a: assert property (s.rsp.bvalid && !axi_req.bready |=> s.rsp.bvalid
		&& $stable(s.rsp.bresp))
		else $error("write response dropped before bready");
	read_hold_a: assert property (s.rsp.rvalid && !axi_req.rready |=> s.rsp.rvalid
		&& $stable(s.rsp.rdata))
		else $error("read data dropped before rready");
	busy_write_a: assert property (s.aw_have || s.rsp.bvalid |-> !s.rsp.awready)
		else $error("write address accepted while busy");
	// interrupt checks: the level follows the masked status, and a rise beats a clear
	irq_level_a: assert property (irq == |(s.irq_stat & s.irq_mask))
		else $error("interrupt level disagrees with masked status");
	irq_set_wins_a: assert property ((comp_raw && !s.completed) |=> s.irq_stat[0])
		else $error("completed rise lost from interrupt status");
	irq_clear_a: assert property ((wr_go && s.aw_addr == IRQ_STAT_OFS && s.w_strb[0] &&
		s.w_data[1] && !(near_raw && !s.near)) |=> !s.irq_stat[1])
		else $error("near status not cleared by writing one");

endmodule

`default_nettype wire

// ===== hw/position_status_pkg.sv
// position_status_pkg: register map, reset values and carrier types of the positioning status
// and speed limit block; assumes a 32-bit AXI4-Lite master and one control clock.
package position_status_pkg;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS       = 8'h00;
	localparam logic [7:0] SELECT_OFS     = 8'h04;
	localparam logic [7:0] COMP_WIDTH_OFS = 8'h08;
	localparam logic [7:0] NEAR_WIDTH_OFS = 8'h0c;
	localparam logic [7:0] INT_LIMIT_OFS  = 8'h10;
	localparam logic [7:0] MAX_SPEED_OFS  = 8'h14;
	localparam logic [7:0] OVERSPEED_OFS  = 8'h18;
	localparam logic [7:0] STATUS_OFS     = 8'h1c;
	localparam logic [7:0] LIMIT_OFS      = 8'h20;
	localparam logic [7:0] IRQ_STAT_OFS   = 8'h24;
	localparam logic [7:0] IRQ_MASK_OFS   = 8'h28;

	// control register fields
	localparam int CTRL_POS_BIT     = 0;
	localparam int CTRL_FORCE_BIT   = 1;
	localparam int CTRL_ALLOC_C_BIT = 4;
	localparam int CTRL_ALLOC_N_BIT = 5;
	localparam int CTRL_ALLOC_V_BIT = 6;
	localparam int CTRL_RESTART_BIT = 8;
	// selector register fields
	localparam int SEL_TIMING_LSB   = 0;
	localparam int SEL_MODE_BIT     = 4;
	localparam int SEL_CEIL_BIT     = 8;
	// status register fields
	localparam int STAT_ACT_TIMING_LSB = 4;
	localparam int STAT_ACT_MODE_BIT   = 8;
	localparam int STAT_ACT_CEIL_BIT   = 12;

	// reset values
	localparam logic [30:0] COMP_WIDTH_RST = 31'h0000_0007;
	localparam logic [30:0] NEAR_WIDTH_RST = 31'h4000_0000;
	localparam logic [15:0] INT_LIMIT_RST  = 16'h2710;
	localparam logic [15:0] MAX_SPEED_RST  = 16'h1388;
	localparam logic [15:0] OVERSPEED_RST  = 16'h157c;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TIMING_ERROR_ONLY = 2'b00,
		TIMING_FILTERED   = 2'b01,
		TIMING_INPUT      = 2'b10
	} timing_t;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axi_rsp_t;

	typedef struct packed {
		axi_rsp_t    rsp;
		logic        aw_have;
		logic [7:0]  aw_addr;
		logic        w_have;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic [6:0]  ctrl;
		logic [1:0]  timing_pend;
		logic        mode_pend;
		logic        ceil_pend;
		timing_t     timing_act;
		logic        mode_act;
		logic        ceil_act;
		logic [30:0] comp_width;
		logic [30:0] near_width;
		logic [15:0] int_limit;
		logic [15:0] max_speed;
		logic [15:0] overspeed;
		logic [15:0] limit;
		logic        completed;
		logic        near;
		logic        vlt;
		logic        completed_out;
		logic        near_out;
		logic        vlt_out;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic        irq;
	} state_t;

endpackage

// ===== tb/host_reader.sv
// host_reader: host controller model that watches the discrete positioning outputs.
// assumes the outputs are synchronous to mclk and already gated by their allocation.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic done_in,
	input  wire logic near_in,
	output var  logic near_lead
);
	logic done_d;

	// a completed rise ends positioning; near already up means the host prepared early
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			done_d <= 1'b0;
			near_lead <= 1'b0;
		end else begin
			done_d <= done_in;
			if (done_in && !done_d)
				near_lead <= near_in;
		end
	end
endmodule
`default_nettype wire

// ===== tb/position_status_speed_limit_tb.sv
// position_status_speed_limit_tb: random and corner tests of the positioning flags, the
// speed limit and the interrupt; assumes a 40 MHz mclk and the package register map.
`timescale 1ns/1ps
`default_nettype none
module position_status_speed_limit_tb;
	import position_status_pkg::*;
	logic               mclk = 1'b0;
	logic               nrst = 1'b0;
	axi_req_t           req = '0;
	axi_rsp_t           rsp;
	logic signed [31:0] ref_c = '0, trav = '0, filt = '0, rin = '0;
	logic signed [15:0] spd = '0;
	logic [15:0]        ext = '0, lim;
	logic               comp, near, vlt, irq, near_lead;
	logic [31:0]        rd;
	logic [1:0]         rs, bs;
	int                 error_cnt = 0;
	int                 cmp_count = 0;
	int                 e, l;
	int                 corner [7] = '{0, 19, 20, -20, 99, 100, -101};
	int                 lm [6][4] = '{'{0, 0, 3000, 0}, '{0, 1, 10000, 0}, '{0, 0, 10000, 0},
		'{1, 0, 10000, 4000}, '{1, 0, 10000, 9000}, '{1, 1, 10000, 9000}};

	always #12.5 mclk = ~mclk;

	position_status dut_u (.mclk(mclk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
		.reference_count(ref_c), .travelled_distance(trav), .filtered_reference(filt),
		.reference_input(rin), .motor_speed(spd), .external_speed_limit_value(ext),
		.positioning_completed_flag(comp), .positioning_near_flag(near),
		.speed_limit_active_flag(vlt), .speed_limit_value(lim), .irq(irq));

	host_reader host_u (.mclk(mclk), .nrst(nrst), .done_in(comp), .near_in(near),
		.near_lead(near_lead));

	function automatic logic exp_comp(int err, int w, int tm, int f, int r);
		int a;
		a = (err < 0) ? -err : err;
		return (a < w) && !(tm == 1 && f != 0) && !(tm == 2 && r != 0);
	endfunction

	// ceiling first picks its source, then the chosen limit is clamped to it
	function automatic int exp_limit(int mode, int ceil, int ilim, int x);
		int c;
		int v;
		c = ceil ? int'(OVERSPEED_RST) : int'(MAX_SPEED_RST);
		v = mode ? x : ilim;
		return (v < c) ? v : c;
	endfunction

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// each channel is released at the edge where its ready is sampled high; the answer is
	// read at the falling edge, where it already holds what the next rising edge will see
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic aw_go;
		logic w_go;
		logic b_go;
		@(posedge mclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge mclk);
			aw_go = req.awvalid && rsp.awready;
			w_go  = req.wvalid && rsp.wready;
			b_go  = req.bready && rsp.bvalid;
			if (b_go)
				bs = rsp.bresp;
			@(posedge mclk);
			if (aw_go)
				req.awvalid <= 1'b0;
			if (w_go)
				req.wvalid <= 1'b0;
			if (b_go) begin
				req.bready <= 1'b0;
				break;
			end
		end
		if (n == 40)
			check("write answer", 32'h1, 32'h0);
	endtask

	task automatic rd_reg(input logic [7:0] a);
		int   n;
		logic ar_go;
		logic r_go;
		@(posedge mclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge mclk);
			ar_go = req.arvalid && rsp.arready;
			r_go  = req.rready && rsp.rvalid;
			if (r_go) begin
				rd = rsp.rdata;
				rs = rsp.rresp;
			end
			@(posedge mclk);
			if (ar_go)
				req.arvalid <= 1'b0;
			if (r_go) begin
				req.rready <= 1'b0;
				break;
			end
		end
		if (n == 40)
			check("read answer", 32'h1, 32'h0);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		rd_reg(a);
		check(nm, exp, rd);
	endtask

	// flags show one edge after the inputs change; vlt needs the limit a cycle earlier, so two
	task automatic drive(input int err, input int f, input int r, input int s, input int x);
		@(posedge mclk);
		ref_c <= 32'sd1000;
		trav <= 32'(1000 - err);
		filt <= 32'(f);
		rin <= 32'(r);
		spd <= 16'(s);
		ext <= 16'(x);
		repeat (3) @(posedge mclk);
		#1;
	endtask

	initial begin
		void'($urandom(32'hd9b29bf2));
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		rd_chk(COMP_WIDTH_OFS, 32'h7, "completed width");
		rd_chk(NEAR_WIDTH_OFS, 32'h4000_0000, "near width");
		rd_chk(INT_LIMIT_OFS, 32'd10000, "internal limit");
		rd_chk(LIMIT_OFS, 32'(exp_limit(0, 0, 10000, 0)), "limit at reset");
		rd_reg(8'h30);
		check("unmapped resp", 32'(RESP_SLVERR), 32'(rs));
		wr(8'h30, 32'h0);
		check("unmapped write resp", 32'(RESP_SLVERR), 32'(bs));
		$display("test reset values done");
		// near width kept above completed width so near leads
		wr(COMP_WIDTH_OFS, 32'd20);
		wr(NEAR_WIDTH_OFS, 32'd100);
		wr(CTRL_OFS, 32'h73);
		for (int i = 0; i < 19; i++) begin
			e = (i < 7) ? corner[i] : int'($urandom_range(240)) - 120;
			drive(e, 0, 0, 0, 0);
			check("completed", 32'(exp_comp(e, 20, 0, 0, 0)), 32'(comp));
			check("near", 32'(exp_comp(e, 100, 0, 0, 0)), 32'(near));
		end
		drive(200, 0, 0, 0, 0);
		drive(50, 0, 0, 0, 0);
		drive(0, 0, 0, 0, 0);
		check("near before completed", 32'h1, 32'(near_lead));
		$display("test width flags done");
		for (int t = 0; t < 3; t++) begin
			wr(SELECT_OFS, 32'(t));
			wr(CTRL_OFS, 32'h173);
			drive(3, 5, 0, 0, 0);
			check("completed filtered", 32'(exp_comp(3, 20, t, 5, 0)), 32'(comp));
			drive(3, 0, 5, 0, 0);
			check("completed input", 32'(exp_comp(3, 20, t, 0, 5)), 32'(comp));
		end
		$display("test timing modes done");
		wr(CTRL_OFS, 32'h03);
		drive(0, 0, 0, 0, 0);
		check("unallocated completed", 32'h0, 32'(comp));
		check("unallocated near", 32'h0, 32'(near));
		rd_reg(STATUS_OFS);
		check("status completed", 32'h1, 32'(rd[0]));
		$display("test allocation done");
		for (int i = 0; i < 6; i++) begin
			wr(SELECT_OFS, 32'((lm[i][0] << 4) | (lm[i][1] << 8)));
			wr(INT_LIMIT_OFS, 32'(lm[i][2]));
			wr(CTRL_OFS, 32'h173);
			l = exp_limit(lm[i][0], lm[i][1], lm[i][2], lm[i][3]);
			drive(0, 0, 0, l - 1, lm[i][3]);
			check("limit", 32'(l), 32'(lim));
			check("vlt below", 32'h0, 32'(vlt));
			drive(0, 0, 0, -l, lm[i][3]);
			check("vlt reached", 32'h1, 32'(vlt));
		end
		wr(CTRL_OFS, 32'h71);
		drive(0, 0, 0, -9000, 0);
		check("vlt without force", 32'h0, 32'(vlt));
		$display("test speed limit done");
		wr(IRQ_MASK_OFS, 32'h1);
		drive(200, 0, 0, 0, 0);
		wr(IRQ_STAT_OFS, 32'h7);
		check("irq cleared", 32'h0, 32'(irq));
		drive(0, 0, 0, 0, 0);
		check("irq raised", 32'h1, 32'(irq));
		rd_chk(IRQ_STAT_OFS, 32'h3, "irq status");
		wr(IRQ_STAT_OFS, 32'h1);
		#1;
		check("irq after clear", 32'h0, 32'(irq));
		$display("test interrupt done");
		complete_run();
	end

	// the whole run is a few hundred cycles; 40000 means a hang
	initial begin
		#(25 * 40000);
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire
